// ---- logic/sbor_pkg.sv ----
// package of constants and carrier types for the standby oscillator recovery block
package sbor_pkg;
   // ************************************************************
   // register map (word offsets as byte addresses)
   // ************************************************************
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_ITC = 4'h4;
   localparam logic [3:0] ADDR_STAT = 4'h8;
   // ctrl fields
   localparam int QUICK_RECOVERY_BIT = 3;
   localparam int LOWPOWER_BUS_GRANT_BIT_POS = 5;
   localparam int STANDBY_SELECT_BIT = 6;
   localparam int CLOCK_DIVIDE_BIT = 7;
   localparam int PERIPHERAL_STOP_BIT = 8;
   localparam int GLOBAL_INTERRUPT_BIT = 9;
   localparam logic [9:0] CTRL_RESET = 10'h000;
   localparam logic [2:0] ITC_RESET = 3'h0;
   // ************************************************************
   // timing counts
   // ************************************************************
   localparam int WAIT_LONG_CYCLES = 131072;
   localparam int WAIT_QUICK_CYCLES = 64;
   localparam int WAIT_W = 18;
   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [1:0] {WAKE_NONE, WAKE_NMI, WAKE_INT_SERVE, WAKE_INT_RESUME} sbor_wake_t;
   typedef struct packed {
      logic wake;
      logic take_interrupt;
      logic nmi;
   } sbor_resume_t;
endpackage

// ---- logic/sbor_top.sv ----
// standby entry, wake-up and stabilization wait controller
// Summary of operation
// - the sleep instruction with peripheral-stop and standby-select both 1 enters standby and stops the oscillator.
// - in standby a low reset, a low nmi or a low enabled external interrupt line starts the exit.
// - in standby an external bus request is granted only when the low-power grant enable is 1.
// - reset picks divide-by-two and afterwards the clock-divide bit picks 0 for two, 1 for one.
// - an external interrupt wake waits 131072 cycles with quick-recovery 0 or 64 cycles with it 1.
// - a bus grant in standby waits the same selected time before the grant is given.
// - a nmi wake, or an enabled interrupt wake with the global flag 1, takes the interrupt.
// - an enabled interrupt wake with the global flag 0 resumes after the sleep instruction.
// - an interrupt line going inactive before the wait ends leaves the block in standby.
`timescale 1ns/1ps
module sbor_top #(
   parameter int WAIT_LONG = sbor_pkg::WAIT_LONG_CYCLES,
   parameter int WAIT_QUICK = sbor_pkg::WAIT_QUICK_CYCLES
) (
   input wire logic clk, // restarted clock
   input wire logic nrst, // async reset, active low
   input wire logic ce, // clock enable
   input wire logic wb_cyc_i, // wishbone cycle
   input wire logic wb_stb_i, // wishbone strobe
   input wire logic wb_we_i, // wishbone write
   input wire logic [3:0] wb_adr_i, // byte address
   input wire logic [3:0] wb_sel_i, // byte lanes
   input wire logic [31:0] wb_dat_i, // write data
   output logic [31:0] wb_dat_o, // read data
   output logic wb_ack_o, // acknowledge
   input wire logic sleep_instruction, // one-cycle pulse from the core
   input wire logic nmi_n, // pin, active low
   input wire logic [2:0] external_interrupt_lines_n, // pins, active low
   input wire logic busreq_n, // pin, active low
   output logic busack_n, // grant, active low
   output logic osc_run, // oscillator enable
   output logic core_clk_en, // core clock gate
   output logic divide_by_one, // clock divide select
   output logic resume_pulse, // one-cycle wake to core
   output logic take_interrupt, // with resume: service interrupt
   output logic nmi_wake // with resume: wake was nmi
);
   // ************************************************************
   // pin synchronisers
   // ************************************************************
   logic [4:0] s1_reg, s2_reg, s3_reg, pin_reg;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s1_reg <= 5'h1f;
         s2_reg <= 5'h1f;
         s3_reg <= 5'h1f;
         pin_reg <= 5'h1f;
      end else if (ce) begin
         s1_reg <= {busreq_n, nmi_n, external_interrupt_lines_n};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         for (int i = 0; i < 5; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
               pin_reg[i] <= s3_reg[i];
            end
         end
      end
   end
   // ************************************************************
   // registers
   // ************************************************************
   logic [9:0] ctrl_reg;
   logic [2:0] itc_reg;
   logic standby_reg;
   logic [sbor_pkg::WAIT_W-1:0] wait_reg;
   logic wr_ctrl, wr_itc, req;
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // writes land at the edge where the master samples ack high
   assign wr_ctrl = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i &&
      wb_adr_i == sbor_pkg::ADDR_CTRL;
   assign wr_itc = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i &&
      wb_adr_i == sbor_pkg::ADDR_ITC;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_reg <= sbor_pkg::CTRL_RESET;
         itc_reg <= sbor_pkg::ITC_RESET;
      end else if (ce) begin
         if (wr_ctrl && wb_sel_i[0]) begin
            ctrl_reg[7:0] <= wb_dat_i[7:0];
         end
         if (wr_ctrl && wb_sel_i[1]) begin
            ctrl_reg[9:8] <= wb_dat_i[9:8];
         end
         if (wr_itc && wb_sel_i[0]) begin
            itc_reg <= wb_dat_i[2:0];
         end
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else if (ce) begin
         wb_ack_o <= req;
         if (req && !wb_we_i) begin
            case (wb_adr_i)
               sbor_pkg::ADDR_CTRL: wb_dat_o <= {22'h0, ctrl_reg};
               sbor_pkg::ADDR_ITC: wb_dat_o <= {29'h0, itc_reg};
               sbor_pkg::ADDR_STAT: wb_dat_o <= {27'h0, ~busack_n, osc_run, core_clk_en,
                  standby_reg, |wait_reg};
               default: wb_dat_o <= 32'h0;
            endcase
         end
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         divide_by_one <= 1'b0;
      end else if (ce) begin
         divide_by_one <= ctrl_reg[sbor_pkg::CLOCK_DIVIDE_BIT];
      end
   end
   // ************************************************************
   // standby sequencing
   // ************************************************************
   typedef enum logic [1:0] {SB_RUN, SB_STOPPED, SB_WAIT, SB_GRANTED} sbor_state_t;
   sbor_state_t state_reg, state_next;
   logic int_act, nmi_act, br_act, br_en, waiting_int;
   logic wake_req, sleep_ok, wait_last, wait_load, wake_done, abandon;
   logic [sbor_pkg::WAIT_W-1:0] wait_len;
   // ************************************************************
   // helpers
   // ************************************************************
   // the loading edge is itself a counted cycle, so the load is one short
   function automatic logic [sbor_pkg::WAIT_W-1:0] wait_length(input logic quick);
      logic [sbor_pkg::WAIT_W-1:0] len;
      if (quick) begin
         len = sbor_pkg::WAIT_W'(WAIT_QUICK - 1);
      end else begin
         len = sbor_pkg::WAIT_W'(WAIT_LONG - 1);
      end
      return len;
   endfunction
   // a low line whose enable is set
   function automatic logic line_active(input logic [2:0] pins_n, input logic [2:0] enables);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < 3; i++) begin
         if (!pins_n[i] && enables[i]) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction
   assign int_act = line_active(pin_reg[2:0], itc_reg);
   assign nmi_act = !pin_reg[3];
   assign wake_req = nmi_act || int_act;
   assign br_en = ctrl_reg[sbor_pkg::LOWPOWER_BUS_GRANT_BIT_POS];
   assign br_act = !pin_reg[4] && br_en;
   assign sleep_ok = sleep_instruction && ctrl_reg[sbor_pkg::PERIPHERAL_STOP_BIT] &&
      ctrl_reg[sbor_pkg::STANDBY_SELECT_BIT];
   assign wait_len = wait_length(ctrl_reg[sbor_pkg::QUICK_RECOVERY_BIT]);
   assign wait_last = wait_reg == sbor_pkg::WAIT_W'(1);
   assign wait_load = state_reg != SB_WAIT && state_next == SB_WAIT;
   assign wake_done = state_reg == SB_WAIT && state_next == SB_RUN;
   // abandon wake
   // a held bus request keeps the wait alive so the grant is not lost
   assign abandon = waiting_int && !wake_req && !br_act;
   assign standby_reg = state_reg != SB_RUN;
   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         SB_RUN: begin
            if (sleep_ok) begin
               state_next = SB_STOPPED;
            end
         end
         SB_STOPPED: begin
            if (wake_req || br_act) begin
               state_next = SB_WAIT;
            end
         end
         SB_WAIT: begin
            if (abandon) begin
               state_next = SB_STOPPED;
            end else if (wait_last && waiting_int && wake_req) begin
               state_next = SB_RUN;
            end else if (wait_last && br_act) begin
               state_next = SB_GRANTED;
            end else if (wait_last) begin
               state_next = SB_STOPPED;
            end
         end
         SB_GRANTED: begin
            if (wake_req) begin
               state_next = SB_WAIT;
            end else if (!br_act) begin
               // grant released: stop again
               state_next = SB_STOPPED;
            end
         end
         default: begin
            state_next = SB_RUN;
         end
      endcase
   end
   // ************************************************************
   // state and counter
   // ************************************************************
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= SB_RUN;
      end else if (ce) begin
         state_reg <= state_next;
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wait_reg <= '0;
      end else if (ce) begin
         if (wait_load) begin
            wait_reg <= wait_len;
         end else if (state_next == SB_WAIT) begin
            wait_reg <= wait_reg - 1'b1;
         end else begin
            wait_reg <= '0;
         end
      end
   end
   // remembers whether an interrupt, not a bus request, started the wait
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         waiting_int <= 1'b0;
      end else if (ce) begin
         if (wait_load) begin
            waiting_int <= wake_req;
         end
      end
   end
   // ************************************************************
   // clock and grant outputs
   // ************************************************************
   // oscillator stops only in SB_STOPPED; it runs through the wait and the grant
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         osc_run <= 1'b1;
      end else if (ce) begin
         osc_run <= state_next != SB_STOPPED;
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         core_clk_en <= 1'b1;
      end else if (ce) begin
         core_clk_en <= state_next == SB_RUN;
      end
   end
   // grant only after the wait
   // an interrupt wait started while granted keeps the grant until it ends
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busack_n <= 1'b1;
      end else if (ce) begin
         if (state_next == SB_GRANTED) begin
            busack_n <= 1'b0;
         end else if (state_next != SB_WAIT) begin
            busack_n <= 1'b1;
         end
      end
   end
   // ************************************************************
   // resume to core
   // ************************************************************
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         resume_pulse <= 1'b0;
      end else if (ce) begin
         resume_pulse <= wake_done;
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         take_interrupt <= 1'b0;
         nmi_wake <= 1'b0;
      end else if (ce) begin
         if (wake_done) begin
            nmi_wake <= nmi_act;
            take_interrupt <= nmi_act || ctrl_reg[sbor_pkg::GLOBAL_INTERRUPT_BIT];
         end
      end
   end
endmodule // sbor_top

// ---- testbench/sbor_far_model.sv ----
// far side: interrupt, nmi and bus-master pins
`timescale 1ns/1ps
module sbor_far_model (
   input wire logic [4:0] req, // bus, nmi, lines 2..0
   output logic [4:0] pin_n // pins, active low
);
   // clock source left free-running: stopping it in standby is optional
   assign pin_n = ~req;
endmodule // sbor_far_model

// ---- testbench/sbor_top_monitor.sv ----
// port assertions for the standby block
`timescale 1ns/1ps
module sbor_top_monitor #(
   parameter int WAIT_LONG = 131072,
   parameter int WAIT_QUICK = 64
) (
   input wire logic clk, // clock
   input wire logic nrst, // reset
   input wire logic sleep_instruction, // sleep
   input wire logic busack_n, // grant
   input wire logic osc_run, // oscillator
   input wire logic core_clk_en, // core gate
   input wire logic divide_by_one, // divide
   input wire logic resume_pulse // wake
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   property p_enter; $fell(core_clk_en) |-> $past(sleep_instruction); endproperty
   a_enter: assert property (p_enter) else $error("gated");
   property p_wake; $rose(osc_run) |-> !core_clk_en; endproperty
   a_wake: assert property (p_wake) else $error("restart");
   property p_grant; !busack_n |-> osc_run; endproperty
   a_grant: assert property (p_grant) else $error("grant");
   property p_div; $rose(nrst) |-> !divide_by_one; endproperty
   a_div: assert property (p_div) else $error("divide");
   property p_gwait; $fell(busack_n) |-> $past(osc_run, WAIT_QUICK - 4); endproperty
   a_gwait: assert property (p_gwait) else $error("early grant");
   property p_wait; resume_pulse |-> $past(osc_run, WAIT_QUICK - 4); endproperty
   a_wait: assert property (p_wait) else $error("early resume");
   property p_run; resume_pulse |=> core_clk_en && !resume_pulse; endproperty
   a_run: assert property (p_run) else $error("core held");
   property p_gate; !osc_run |-> !core_clk_en; endproperty
   a_gate: assert property (p_gate) else $error("core clocked");
endmodule // sbor_top_monitor
bind sbor_top sbor_top_monitor #(.WAIT_LONG(WAIT_LONG), .WAIT_QUICK(WAIT_QUICK))
   u_sbor_top_monitor (.clk, .nrst, .sleep_instruction, .busack_n, .osc_run,
   .core_clk_en, .divide_by_one, .resume_pulse);

// ---- testbench/sbor_top_tb.sv ----
// bench for the standby block
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
$display("Error %0t %h %h", $time, a, e); end end
module sbor_top_tb;
   logic clk = 1'b0, nrst = 1'b0, cyc = 1'b0, we = 1'b0, sl = 1'b0, ack, bk, osc, cke, d1, res;
   logic ti, nw;
   logic [3:0] adr = 4'h0;
   logic [4:0] rq = 5'h0;
   logic [31:0] wd = 32'h0, dat;
   wire logic [4:0] pn;
   int failures = 0, n_checks = 0, n = 0;
   sbor_top #(.WAIT_LONG(200)) u_sbor_top (.clk, .nrst, .ce(1'b1), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd),
      .wb_dat_o(dat), .wb_ack_o(ack), .sleep_instruction(sl), .nmi_n(pn[3]),
      .external_interrupt_lines_n(pn[2:0]), .busreq_n(pn[4]), .busack_n(bk), .osc_run(osc),
      .core_clk_en(cke), .divide_by_one(d1), .resume_pulse(res), .take_interrupt(ti),
      .nmi_wake(nw));
   sbor_far_model u_sbor_far_model (.req(rq), .pin_n(pn));
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      cyc <= 1'b1; we <= w; adr <= a; wd <= d;
      do @(posedge clk); while (ack !== 1'b1);
      cyc <= 1'b0; @(posedge clk);
   endtask
   task automatic till(ref logic s, input logic v);
      for (n = 0; s !== v && n < 999; n++) @(posedge clk);
   endtask
   task automatic enter(input logic [31:0] c);
      wb(1'b1, 4'h0, c);
      sl <= 1'b1; @(posedge clk); sl <= 1'b0; repeat (3) @(posedge clk);
      `CHK({osc, cke}, 2'h0)
   endtask
   task automatic wake(input logic [4:0] r, input int w, input logic [1:0] f);
      rq <= r; till(osc, 1'b1); till(res, 1'b1);
      `CHK(n >= w - 1 && n <= w + 2, 1'b1)
      `CHK({nw, ti}, f)
      rq <= 5'h0; @(posedge clk);
   endtask
   task automatic t_int(input logic q, input logic g, input int w);
      wb(1'b1, 4'h4, 32'h4); enter({22'h0, g, 5'h14, q, 3'h0}); rq <= 5'h01;
      repeat (20) @(posedge clk);
      `CHK(osc, 1'b0)
      wake(5'h05, w, {1'b0, g});
   endtask
   task automatic t_abort;
      enter(32'h148); rq <= 5'h04; till(osc, 1'b1); repeat (20) @(posedge clk);
      rq <= 5'h00; repeat (9) @(posedge clk);
      `CHK({osc, cke, res}, 3'h0)
      wake(5'h08, 64, 2'h3);
   endtask
   task automatic t_bus;
      enter(32'h148); rq <= 5'h10; repeat (99) @(posedge clk);
      `CHK({bk, osc}, 2'h2)
      wake(5'h08, 64, 2'h3);
      enter(32'h168); rq <= 5'h10; till(osc, 1'b1); till(bk, 1'b0);
      `CHK(n >= 63 && n <= 66, 1'b1)
      rq <= 5'h00; repeat (9) @(posedge clk);
      `CHK({bk, osc}, 2'h2)
      wake(5'h08, 64, 2'h3);
   endtask
   task automatic t_rst;
      enter(32'h148);
      // reset held low while the clock source settles
      nrst <= 1'b0;
      repeat (6) @(posedge clk);
      `CHK({osc, cke, bk, res}, 4'he)
      nrst <= 1'b1;
      @(posedge clk);
      wb(1'b0, 4'h0, 32'h0);
      `CHK({dat, d1}, 33'h0)
   endtask
   initial forever #12.5 clk = ~clk;
   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1'b1; @(posedge clk);
      `CHK(d1, 1'b0)
      wb(1'b1, 4'h0, 32'h80); wb(1'b0, 4'h0, 32'h0);
      `CHK({dat, d1}, 33'h101)
      wb(1'b0, 4'hc, 32'h0);
      `CHK(dat, 32'h0)
      t_int(1'b1, 1'b1, 64);
      t_int(1'b0, 1'b0, 200);
      t_abort();
      t_bus();
      t_rst();
      final_report();
   end
   initial begin
      #100000; failures++; final_report();
   end
   task automatic final_report;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
endmodule // sbor_top_tb
